// ==== hw/plmhs_pkg.sv ====
// Shared constants and types for the power line modem host serial block
package plmhs_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BAUD_RATE    = 1200;
  localparam int unsigned OVERSAMPLE   = 16;
  localparam int unsigned BAUD_DIV     = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
  localparam int unsigned TICK_NS      = 555_560;
  localparam int unsigned TICK_CYCLES  = TICK_NS / CLK_PERIOD_NS;
  localparam logic [9:0]  TIMER_START  = 10'h2FF;
  localparam logic [3:0]  SAMPLE_LAST  = 4'hF;
  localparam logic [3:0]  SAMPLE_MID   = 4'h7;
  localparam logic [3:0]  RX_BITS      = 4'h9;
  localparam logic [3:0]  TX_BITS      = 4'hB;
  localparam logic [2:0]  LVL_TICK     = 3'h0;
  localparam logic [2:0]  LVL_ONE      = 3'h1;
  localparam logic [2:0]  LVL_IDLE     = 3'h7;
  localparam int unsigned NSRC         = 6;
  localparam logic [2:0]  SRC_NMI      = 3'h0;
  localparam logic [2:0]  SRC_TICK     = 3'h1;
  localparam logic [2:0]  SRC_EXT      = 3'h2;
  localparam logic [2:0]  SRC_HDR      = 3'h3;
  localparam logic [2:0]  SRC_RXD      = 3'h4;
  localparam logic [2:0]  SRC_TXE      = 3'h5;
  typedef enum logic [2:0] {
    INIT_CLOCK, INIT_STACK, INIT_PORT, INIT_REGF, INIT_SERIAL, INIT_TIMER, INIT_RUN
  } plmhs_init_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} plmhs_rx_t;
endpackage

// ==== hw/plmhs_top.sv ====
// Top of the power line modem host serial block: timer, serial port, interrupts
`timescale 1ns/1ns
`default_nettype none
module plmhs_top
  import plmhs_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES,
  parameter int unsigned P_BAUD_DIV    = BAUD_DIV
)(
  input  wire logic            i_sys_clk,
  input  wire logic            i_nrst,
  input  wire logic            i_rxd,
  input  wire logic            i_carrier_detect_n,
  input  wire logic            i_modem_reset_out,
  input  wire logic            i_rx_tx_sel,
  input  wire logic [7:0]      i_header_cmp,
  input  wire logic [7:0]      i_tx_data,
  input  wire logic            i_tx_write,
  input  wire logic [NSRC-1:0] i_irq_clr,
  output logic                 o_txd,
  output logic                 o_tx_ready,
  output logic [7:0]           o_rx_data,
  output logic                 o_rx_parity_err,
  output logic                 o_rx_stop_err,
  output logic                 o_rx_valid,
  output logic [1:0]           o_port_out,
  output logic                 o_net_update,
  output logic                 o_init_done,
  output logic [NSRC-1:0]      o_irq_pending,
  output logic                 o_irq_req,
  output logic                 o_nmi_req,
  output logic [2:0]           o_irq_src,
  output logic [2:0]           o_irq_level
);
  localparam int unsigned PRESC_RAW = P_TICK_CYCLES / (int'(TIMER_START) + 1);
  localparam int unsigned PRESC     = (PRESC_RAW < 1) ? 1 : PRESC_RAW;

  function automatic logic [2:0] src_level(input logic [2:0] src);
    if (src == SRC_TICK) begin
      src_level = LVL_TICK;
    end else if (src == SRC_NMI) begin
      src_level = LVL_TICK;
    end else begin
      src_level = LVL_ONE;
    end
  endfunction

  plmhs_init_t init_state;
  logic        run;
  logic [15:0] presc_cnt;
  logic        presc_en;
  logic [9:0]  timer;
  logic        tick;
  logic [15:0] baud_cnt;
  logic        sample_en;
  logic        cd_prev;
  logic        rst_prev;
  logic        cd_fall;
  logic        rst_rise;
  plmhs_rx_t   rx_state;
  logic [3:0]  rx_scnt;
  logic [3:0]  rx_bcnt;
  logic [8:0]  rx_sh;
  logic        rx_done;
  logic        hdr_match;
  logic        tx_busy;
  logic        tx_done;
  logic        wd_kick;
  logic [NSRC-1:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequence, one step per cycle, timer held until the end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      init_state <= INIT_CLOCK;
    end else begin
      case (init_state)
        INIT_CLOCK:  init_state <= INIT_STACK;
        INIT_STACK:  init_state <= INIT_PORT;
        INIT_PORT:   init_state <= INIT_REGF;
        INIT_REGF:   init_state <= INIT_SERIAL;
        INIT_SERIAL: init_state <= INIT_TIMER;
        INIT_TIMER:  init_state <= INIT_RUN;
        INIT_RUN:    init_state <= INIT_RUN;
        default:     init_state <= INIT_CLOCK;
      endcase
    end
  end

  assign run         = (init_state == INIT_RUN);
  assign o_init_done = run;

  ////////////////////////////////////////////////////////////////////////////
  // Tick timer: prescaler feeding a reloading down-counter
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      presc_cnt <= 16'h0000;
    end else if (!run || presc_cnt == 16'(PRESC - 1)) begin
      presc_cnt <= 16'h0000;
    end else begin
      presc_cnt <= presc_cnt + 16'h0001;
    end
  end

  assign presc_en = run && (presc_cnt == 16'(PRESC - 1));
  assign tick     = presc_en && (timer == 10'h000);

  // Underflow only reloads and ticks; nothing here resets the host
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer <= TIMER_START;
    end else if (presc_en) begin
      timer <= (timer == 10'h000) ? TIMER_START : timer - 10'h001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_net_update <= 1'b0;
    end else begin
      o_net_update <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port outputs: bit 0 Rx/Tx select, bit 1 watchdog kick toggled per tick
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wd_kick <= 1'b0;
    end else if (tick) begin
      wd_kick <= ~wd_kick;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_port_out <= 2'b00;
    end else begin
      o_port_out <= {wd_kick, i_rx_tx_sel};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud divider: one sample enable per sixteenth of a bit
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      baud_cnt <= 16'h0000;
    end else if (baud_cnt == 16'(P_BAUD_DIV - 1)) begin
      baud_cnt <= 16'h0000;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
    end
  end

  assign sample_en = (baud_cnt == 16'(P_BAUD_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: start found low, bits taken mid-cell every sixteen samples
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_state <= RX_IDLE;
      rx_scnt  <= 4'h0;
      rx_bcnt  <= 4'h0;
      rx_sh    <= 9'h000;
    end else if (sample_en && run) begin
      rx_scnt <= rx_scnt + 4'h1;
      case (rx_state)
        RX_IDLE: begin
          rx_scnt <= 4'h0;
          if (!i_rxd) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_scnt == SAMPLE_MID) begin
            rx_scnt  <= 4'h0;
            rx_bcnt  <= 4'h0;
            rx_state <= i_rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_scnt == SAMPLE_LAST) begin
            rx_sh   <= {i_rxd, rx_sh[8:1]};
            rx_bcnt <= rx_bcnt + 4'h1;
            if (rx_bcnt == RX_BITS - 4'h1) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_scnt == SAMPLE_LAST) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  assign rx_done   = sample_en && run && rx_state == RX_STOP && rx_scnt == SAMPLE_LAST;
  assign hdr_match = rx_done && (rx_sh[7:0] == i_header_cmp);

  // Data and error flags stand until the next character
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_data       <= 8'h00;
      o_rx_parity_err <= 1'b0;
      o_rx_stop_err   <= 1'b0;
      o_rx_valid      <= 1'b0;
    end else begin
      o_rx_valid <= rx_done;
      if (rx_done) begin
        o_rx_data       <= rx_sh[7:0];
        o_rx_parity_err <= ~^rx_sh;
        o_rx_stop_err   <= ~i_rxd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  plmhs_tx u_tx (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_sample_en (sample_en),
    .i_load      (i_tx_write && run),
    .i_data      (i_tx_data),
    .o_txd       (o_txd),
    .o_busy      (tx_busy),
    .o_done      (tx_done)
  );

  assign o_tx_ready = run && !tx_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on carrier detect and modem reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cd_prev  <= 1'b1;
      rst_prev <= 1'b0;
    end else begin
      cd_prev  <= i_carrier_detect_n;
      rst_prev <= i_modem_reset_out;
    end
  end

  assign cd_fall  = run && cd_prev && !i_carrier_detect_n;
  assign rst_rise = run && !rst_prev && i_modem_reset_out;

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags; a new event wins over a clear in the same cycle
  always_comb begin
    events           = '0;
    events[SRC_NMI]  = rst_rise;
    events[SRC_TICK] = tick;
    events[SRC_EXT]  = cd_fall;
    events[SRC_HDR]  = hdr_match;
    events[SRC_RXD]  = rx_done;
    events[SRC_TXE]  = tx_done;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_pend
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_irq_pending[gi] <= 1'b0;
        end else if (events[gi]) begin
          o_irq_pending[gi] <= 1'b1;
        end else if (i_irq_clr[gi]) begin
          o_irq_pending[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Lowest index wins: reset, tick, then the level-one sources
  always_comb begin
    o_irq_src = SRC_NMI;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (o_irq_pending[i]) begin
        o_irq_src = 3'(i);
      end
    end
  end

  assign o_irq_req   = |o_irq_pending;
  assign o_nmi_req   = o_irq_pending[SRC_NMI];
  assign o_irq_level = o_irq_req ? src_level(o_irq_src) : LVL_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reload;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    tick |=> timer == TIMER_START;
  endproperty
  a_reload: assert property (p_reload)
    else $error("timer not reloaded");

  property p_hold_till_run;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !run |-> timer == TIMER_START && !tick;
  endproperty
  a_hold_till_run: assert property (p_hold_till_run)
    else $error("timer moved before start-up");

  property p_kick;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    tick |=> ##1 o_port_out[1] != $past(o_port_out[1], 2);
  endproperty
  a_kick: assert property (p_kick)
    else $error("watchdog not kicked");

  property p_nmi_top;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_irq_pending[SRC_NMI] |-> o_irq_src == SRC_NMI;
  endproperty
  a_nmi_top: assert property (p_nmi_top)
    else $error("reset interrupt outranked");

  property p_tick_lvl;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_irq_pending[SRC_TICK] && !o_irq_pending[SRC_NMI] |-> o_irq_level == LVL_TICK;
  endproperty
  a_tick_lvl: assert property (p_tick_lvl)
    else $error("tick not level 0");

  property p_idle_lvl;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_irq_pending == '0 |-> o_irq_level == LVL_IDLE && !o_irq_req;
  endproperty
  a_idle_lvl: assert property (p_idle_lvl)
    else $error("idle level not 7");

  property p_cd_fall;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    run && $fell(i_carrier_detect_n) |=> o_irq_pending[SRC_EXT];
  endproperty
  a_cd_fall: assert property (p_cd_fall)
    else $error("carrier edge lost");

  property p_hdr;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    hdr_match |=> o_irq_pending[SRC_HDR] && o_irq_pending[SRC_RXD] && o_rx_valid;
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("header match lost");

  property p_ser_lvl;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_irq_req && o_irq_src >= SRC_EXT |-> o_irq_level == LVL_ONE;
  endproperty
  a_ser_lvl: assert property (p_ser_lvl)
    else $error("serial level not 1");
endmodule
`default_nettype wire

// ==== hw/plmhs_tx.sv ====
// Serial character transmitter of the power line modem host serial block
`timescale 1ns/1ns
`default_nettype none
module plmhs_tx
  import plmhs_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_sample_en,
  input  wire logic       i_load,
  input  wire logic [7:0] i_data,
  output logic            o_txd,
  output logic            o_busy,
  output logic            o_done
);
  logic [10:0] shreg;
  logic [3:0]  scnt;
  logic [3:0]  bcnt;

  // Frame is stop, odd parity, data, start; shifted out LSB first
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shreg  <= 11'h7FF;
      scnt   <= 4'h0;
      bcnt   <= 4'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && i_load) begin
        shreg  <= {1'b1, ~^i_data, i_data, 1'b0};
        scnt   <= 4'h0;
        bcnt   <= 4'h0;
        o_busy <= 1'b1;
      end else if (o_busy && i_sample_en) begin
        scnt <= scnt + 4'h1;
        if (scnt == SAMPLE_LAST) begin
          shreg <= {1'b1, shreg[10:1]};
          bcnt  <= bcnt + 4'h1;
          if (bcnt == TX_BITS - 4'h1) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
        end
      end
    end
  end

  // Push-pull line, idles high
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_txd <= 1'b1;
    end else begin
      o_txd <= o_busy ? shreg[0] : 1'b1;
    end
  end

  property p_tx_start_low;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (!o_busy && i_load) |=> ##1 !o_txd;
  endproperty
  a_tx_start_low: assert property (p_tx_start_low)
    else $error("start bit not low");

  property p_tx_done_frees;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_done |-> !o_busy && $past(o_busy);
  endproperty
  a_tx_done_frees: assert property (p_tx_done_frees)
    else $error("done without end of frame");
endmodule
`default_nettype wire

// ==== tb/plmhs_modem_model.sv ====
// Behavioural model of the power line modem on the serial side of the block
`timescale 1ns/1ns
`default_nettype none
module plmhs_modem_model #(
  parameter int unsigned P_BIT = 64
)(
  input  wire logic i_sys_clk,
  input  wire logic i_txd,
  output logic      o_rxd,
  output logic      o_carrier_detect_n,
  output logic      o_modem_reset_out
);
  initial begin
    o_rxd              = 1'b1;
    o_carrier_detect_n = 1'b1;
    o_modem_reset_out  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Sends one character; parity may be broken and the stop level chosen
  task automatic send_char(input logic [7:0] d, input logic bad_par, input logic stop);
    logic [10:0] frame;
    frame = {stop, ~(^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge i_sys_clk);
      o_rxd = frame[i];
      repeat (P_BIT - 1) @(negedge i_sys_clk);
    end
    @(negedge i_sys_clk);
    o_rxd = 1'b1;
  endtask
  // Samples one character from the transmit line at mid bit
  task automatic capture(output logic [7:0] d, output logic p, output logic s);
    int n;
    n = 0;
    while (i_txd !== 1'b0 && n < 4000) begin
      @(negedge i_sys_clk);
      n++;
    end
    repeat (P_BIT / 2) @(negedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (P_BIT) @(negedge i_sys_clk);
      d[i] = i_txd;
    end
    repeat (P_BIT) @(negedge i_sys_clk);
    p = i_txd;
    repeat (P_BIT) @(negedge i_sys_clk);
    s = i_txd;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic carrier_fall();
    @(negedge i_sys_clk);
    o_carrier_detect_n = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    o_carrier_detect_n = 1'b1;
  endtask
  task automatic reset_pulse();
    @(negedge i_sys_clk);
    o_modem_reset_out = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    o_modem_reset_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_powerline_modem_host_serial.sv ====
// Self-checking testbench of the power line modem host serial block
`timescale 1ns/1ns
`default_nettype none
module test_powerline_modem_host_serial;
  import plmhs_pkg::*;
  localparam int unsigned P_BAUD = 4;
  localparam int unsigned P_TICK = 768;
  localparam int unsigned P_BIT  = 16 * P_BAUD;
  logic            i_sys_clk    = 1'b0;
  logic            i_nrst       = 1'b0;
  logic            i_rx_tx_sel  = 1'b0;
  logic [7:0]      i_header_cmp = 8'hAA;
  logic [7:0]      i_tx_data    = 8'h00;
  logic            i_tx_write   = 1'b0;
  logic [NSRC-1:0] i_irq_clr    = '0;
  logic            rxd;
  logic            cd_n;
  logic            mrst;
  logic            o_txd;
  logic            o_tx_ready;
  logic [7:0]      o_rx_data;
  logic            o_rx_parity_err;
  logic            o_rx_stop_err;
  logic            o_rx_valid;
  logic [1:0]      o_port_out;
  logic            o_net_update;
  logic            o_init_done;
  logic [NSRC-1:0] o_irq_pending;
  logic            o_irq_req;
  logic            o_nmi_req;
  logic [2:0]      o_irq_src;
  logic [2:0]      o_irq_level;
  int              miscompares = 0;
  int              n_compared  = 0;
  int              cycles      = 0;

  always #25 i_sys_clk = ~i_sys_clk;

  plmhs_top #(.P_TICK_CYCLES(P_TICK), .P_BAUD_DIV(P_BAUD)) plmhs_top_i (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_rxd(rxd), .i_carrier_detect_n(cd_n),
    .i_modem_reset_out(mrst), .i_rx_tx_sel(i_rx_tx_sel), .i_header_cmp(i_header_cmp),
    .i_tx_data(i_tx_data), .i_tx_write(i_tx_write), .i_irq_clr(i_irq_clr),
    .o_txd(o_txd), .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data),
    .o_rx_parity_err(o_rx_parity_err), .o_rx_stop_err(o_rx_stop_err),
    .o_rx_valid(o_rx_valid), .o_port_out(o_port_out), .o_net_update(o_net_update),
    .o_init_done(o_init_done), .o_irq_pending(o_irq_pending), .o_irq_req(o_irq_req),
    .o_nmi_req(o_nmi_req), .o_irq_src(o_irq_src), .o_irq_level(o_irq_level));

  plmhs_modem_model #(.P_BIT(P_BIT)) plmhs_modem_model_i (
    .i_sys_clk(i_sys_clk), .i_txd(o_txd), .o_rxd(rxd),
    .o_carrier_detect_n(cd_n), .o_modem_reset_out(mrst));
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_v({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic clr(input logic [NSRC-1:0] m);
    @(negedge i_sys_clk);
    i_irq_clr = m;
    @(negedge i_sys_clk);
    i_irq_clr = '0;
  endtask
  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(negedge i_sys_clk);
      cnt++;
    end while (o_net_update !== 1'b1 && cnt < 3000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (6) @(negedge i_sys_clk);
    chk_b(o_txd, 1'b1);
    chk_v({13'h0000, o_irq_level}, 16'h0007);
    chk_b(o_irq_req, 1'b0);
    i_nrst = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    chk_b(o_init_done, 1'b0);
    @(negedge i_sys_clk);
    chk_b(o_init_done, 1'b1);
    chk_b(o_tx_ready, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_sel();
    i_rx_tx_sel = 1'b1;
    @(negedge i_sys_clk);
    chk_b(o_port_out[0], 1'b1);
    i_rx_tx_sel = 1'b0;
    @(negedge i_sys_clk);
    chk_b(o_port_out[0], 1'b0);
    $display("test select done");
  endtask
  task automatic t_tx();
    logic [7:0] d;
    logic       p;
    logic       s;
    int         n;
    i_tx_data  = 8'h5A;
    i_tx_write = 1'b1;
    @(negedge i_sys_clk);
    i_tx_write = 1'b0;
    chk_b(o_tx_ready, 1'b0);
    @(negedge i_sys_clk);
    i_tx_data  = 8'hC3;
    i_tx_write = 1'b1;
    @(negedge i_sys_clk);
    i_tx_write = 1'b0;
    plmhs_modem_model_i.capture(d, p, s);
    chk_v({8'h00, d}, 16'h005A);
    chk_b(p, ~(^8'h5A));
    chk_b(s, 1'b1);
    n = 0;
    while (o_irq_pending[5] !== 1'b1 && n < 300) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk_b(o_irq_pending[5], 1'b1);
    chk_b(o_tx_ready, 1'b1);
    wait_tick(n);
    clr(6'h1F);
    chk_v({10'h000, o_irq_pending}, 16'h0020);
    chk_v({13'h0000, o_irq_level}, 16'h0001);
    clr(6'h20);
    $display("test transmit done");
  endtask
  task automatic rx_one(input logic [7:0] d, input logic bad, input logic stop,
                        input logic hdr);
    int n;
    n = 0;
    fork
      plmhs_modem_model_i.send_char(d, bad, stop);
      begin
        while (o_rx_valid !== 1'b1 && n < 1500) begin
          @(negedge i_sys_clk);
          n++;
        end
        chk_b(o_rx_valid, 1'b1);
      end
    join
    chk_v({8'h00, o_rx_data}, {8'h00, d});
    chk_b(o_rx_parity_err, bad);
    chk_b(o_rx_stop_err, ~stop);
    chk_b(o_irq_pending[3], hdr);
    chk_b(o_irq_pending[4], 1'b1);
    clr(6'h18);
  endtask
  task automatic t_rx();
    rx_one(8'hAA, 1'b0, 1'b1, 1'b1);
    rx_one(8'h3C, 1'b1, 1'b1, 1'b0);
    rx_one(8'hAA, 1'b0, 1'b0, 1'b1);
    $display("test receive done");
  endtask
  task automatic t_tick();
    logic k;
    int   n;
    int   w;
    wait_tick(w);
    chk_b(o_net_update, 1'b1);
    k = o_port_out[1];
    repeat (2) @(negedge i_sys_clk);
    chk_b(o_port_out[1], ~k);
    clr(6'h3F);
    wait_tick(w);
    // Two cycles for the kick check and two for the clear precede the wait
    n = w + 4;
    chk_v(16'(n), 16'(P_TICK));
    chk_v({10'h000, o_irq_pending}, 16'h0002);
    chk_v({13'h0000, o_irq_level}, 16'h0000);
    clr(6'h02);
    plmhs_modem_model_i.carrier_fall();
    chk_v({10'h000, o_irq_pending}, 16'h0004);
    chk_v({13'h0000, o_irq_level}, 16'h0001);
    plmhs_modem_model_i.reset_pulse();
    chk_b(o_nmi_req, 1'b1);
    chk_b(o_irq_req, 1'b1);
    chk_v({13'h0000, o_irq_src}, 16'h0000);
    $display("test tick and events done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    t_reset();
    t_sel();
    t_tx();
    t_rx();
    t_tick();
    close_out();
  end
endmodule
`default_nettype wire
